/* verilog/oog_overhead_gen.v */
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "oog_defs.vh"
// Summary of operation
// - frame types OTU1 to OTU4 with variants, each with its nominal line rate.
// - legal client payloads depend on frame type and application (cfg_ok checks application only); OTN: PRBS or null.
// - first mux stage used only with two or more levels; picks higher-order unit.
// - payload type 20 uses 2.5G slots, payload type 21 uses 1.25G slots.
// - second mux stage only with three levels; none, 2.1, 12 variants or 01.
// - third mux stage only for 40G or 100G frames; none or 01.
// - six alignment bytes default F6 F6 F6 28 28 28, each overridable.
// - altered alignment bytes are sent unchanged even if far end loses alignment.
// - multiframe byte counts frames, one per frame, wrapping 255 to 0.
// - section monitoring is trace byte, parity byte, and status byte; code sends the parity byte as written to oh_mem.
// - status byte: error count bits 1-4, defect bit 5, alignment bit 6, 7-8 reserved.
// - 64-byte trace sent one byte per frame, aligned to multiframe count.
// - trace holds source id, destination id and 32-byte operator field.
// - error codes 0000-1000 mean 0-8 violations; 1001-1111 mean zero.
// - only code 1011 signals backward incoming alignment error.
// - defect bit is 1 while signal fail is reported, else 0; code also sets it while sm3_a_q[3] is set.
// - alignment error bit is 1 while frame alignment error reported, else 0; code also sets it while sm3_a_q[2] is set.
// - overhead carries comm channels, reserved, tandem, fault, path, exp, protection, PSI.
module oog_overhead_gen #(
  parameter ROW_LEN = `OOG_ROW_LEN
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [3:0]  rx_bip_cnt,
  input  wire        rx_biae,
  input  wire        rx_sf,
  input  wire        rx_iae,
  output reg  [7:0]  ov_data,
  output reg         ov_valid,
  output reg         ov_sof,
  output reg         ov_oh,
  output reg  [16:0] line_rate_q,
  output reg         ts_2g5_q,
  output reg         irq
);

  // ****************************************
  // helper functions
  // ****************************************
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction
  function [16:0] rate_mbps;
    input [3:0] t;
    begin
      case (t)
        4'd0:    rate_mbps = 17'd2666;
        4'd1:    rate_mbps = 17'd10709;
        4'd2:    rate_mbps = 17'd10709;
        4'd3:    rate_mbps = 17'd11049;
        4'd4:    rate_mbps = 17'd11096;
        4'd5:    rate_mbps = 17'd11270;
        4'd6:    rate_mbps = 17'd11318;
        4'd7:    rate_mbps = 17'd43018;
        4'd8:    rate_mbps = 17'd44571;
        4'd9:    rate_mbps = 17'd44583;
        4'd10:   rate_mbps = 17'd111810;
        default: rate_mbps = 17'd0;
      endcase
    end
  endfunction
  // first-stage codes whose unit runs on 2.5G slots
  function ts_2g5;
    input [4:0] m1;
    begin
      case (m1)
        5'd7, 5'd8, 5'd11, 5'd14, 5'd17: ts_2g5 = 1'b1;
        default:                         ts_2g5 = 1'b0;
      endcase
    end
  endfunction
  function cfg_ok;
    input [31:0] c;
    reg   ok_cl;
    begin
      ok_cl = 1'b0;
      case (c[`OOG_C_APP])
        3'd0:    ok_cl = (c[`OOG_C_CLIENT] < 5'd2);
        3'd2:    ok_cl = 1'b1;
        3'd1, 3'd3, 3'd4: ok_cl = (c[`OOG_C_CLIENT] >= 5'd2);
        default: ok_cl = 1'b0;
      endcase
      cfg_ok = ok_cl && (c[`OOG_C_OTYPE] <= 4'd10)
        && (c[`OOG_C_MUX1] <= 5'd19) && (c[`OOG_C_MUX2] <= 3'd4)
        && (c[`OOG_C_NLEV] >= 2'd2 || c[`OOG_C_MUX1] == 5'd0)
        && (c[`OOG_C_NLEV] == 2'd3 || c[`OOG_C_MUX2] == 3'd0)
        && (!c[`OOG_C_MUX3] || c[`OOG_C_OTYPE] >= 4'd7);
    end
  endfunction
  // codes above eight read as zero at the far end, so clamp instead
  function [3:0] bei_enc;
    input [3:0] cnt;
    input       biae;
    begin
      if (biae) begin
        bei_enc = 4'b1011;
      end else if (cnt > 4'd8) begin
        bei_enc = 4'b1000;
      end else begin
        bei_enc = cnt;
      end
    end
  endfunction
  function [7:0] prbs_step;
    input [30:0] s;
    reg   [30:0] t;
    integer i;
    begin
      t = s;
      for (i = 0; i < 8; i = i + 1) begin
        t = {t[29:0], t[30] ^ t[27]};
      end
      prbs_step = t[7:0];
    end
  endfunction
  // ****************************************
  // state
  // ****************************************
  reg [31:0] cfg_s_q;
  reg [31:0] cfg_a_q;
  reg [47:0] fas_s_q;
  reg [47:0] fas_a_q;
  reg [7:0]  sm3_s_q;
  reg [7:0]  sm3_a_q;
  reg [3:0]  int_en_q;
  reg [3:0]  int_stat_q;
  reg        commit_q;
  reg        cfg_err_q;
  reg        bank_q;
  reg [7:0]  mfas_q;
  reg [13:0] col_q;
  reg [1:0]  row_q;
  reg [30:0] prbs_q;
  reg [7:0]  aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  reg [7:0]  oh_mem  [0:127];
  reg [7:0]  tti_mem [0:127];

  wire       wr_go   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire       en      = cfg_s_q[`OOG_C_EN];
  wire       last    = (row_q == 2'd3) && (col_q == ROW_LEN - 1);
  wire       fb      = ~en | last;
  wire       wr_ctrl = wr_go && (aw_addr_q == `OOG_A_CTRL);
  wire       wr_clr  = wr_go && (aw_addr_q == `OOG_A_INT_CLR);
  wire       req_cm  = wr_ctrl && w_strb_q[0] && w_data_q[`OOG_C_COMMIT];
  wire       cfg_good = cfg_ok(cfg_s_q);
  wire [3:0] clr_bits = wr_clr ? w_data_q[3:0] : 4'h0;
  wire [31:0] fas_hi_m = merge({16'h0000, fas_s_q[15:0]}, w_data_q, w_strb_q);
  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a[1:0] == 2'b00) && (a <= `OOG_A_INT_EN);
    end
  endfunction

  // ****************************************
  // axi4-lite write side
  // ****************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `OOG_RESP_OK;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      cfg_s_q       <= 32'h0000_0000;
      fas_s_q       <= `OOG_FAS_RST;
      sm3_s_q       <= `OOG_SM3_RST;
      int_en_q      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_ok(aw_addr_q) ? `OOG_RESP_OK : `OOG_RESP_ERR;
        case (aw_addr_q)
          `OOG_A_CTRL: begin
            cfg_s_q <= merge(cfg_s_q, w_data_q, w_strb_q) & 32'h07FF_FFFD;
          end
          `OOG_A_FAS_LO: begin
            fas_s_q[47:16] <= merge(fas_s_q[47:16], w_data_q, w_strb_q);
          end
          `OOG_A_FAS_HI: begin
            fas_s_q[15:0] <= fas_hi_m[15:0];
          end
          `OOG_A_SM3: begin
            if (w_strb_q[0]) begin
              sm3_s_q <= w_data_q[7:0];
            end
          end
          `OOG_A_INT_EN: begin
            if (w_strb_q[0]) begin
              int_en_q <= w_data_q[3:0];
            end
          end
          default: begin end
        endcase
      end
    end
  end

  // software fills the bank not on air; the frame never sees a partial edit
  always @(posedge clk) begin
    if (wr_go && w_strb_q[0] && w_strb_q[1]) begin
      if (aw_addr_q == `OOG_A_OHW) begin
        oh_mem[{~bank_q, w_data_q[13:8]}] <= w_data_q[7:0];
      end
      if (aw_addr_q == `OOG_A_TTIW) begin
        tti_mem[{~bank_q, w_data_q[13:8]}] <= w_data_q[7:0];
      end
    end
  end

  // ****************************************
  // axi4-lite read side
  // ****************************************
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `OOG_A_CTRL:     rd_mux = {cfg_s_q[31:2], commit_q, cfg_s_q[0]};
      `OOG_A_FAS_LO:   rd_mux = fas_s_q[47:16];
      `OOG_A_FAS_HI:   rd_mux = {16'h0000, fas_s_q[15:0]};
      `OOG_A_SM3:      rd_mux = {24'h00_0000, sm3_s_q};
      `OOG_A_STAT:     rd_mux = {21'h00_0000, commit_q, cfg_err_q, bank_q, mfas_q};
      `OOG_A_RATE:     rd_mux = {15'h0000, line_rate_q};
      `OOG_A_INT_STAT: rd_mux = {28'h000_0000, int_stat_q};
      `OOG_A_INT_EN:   rd_mux = {28'h000_0000, int_en_q};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `OOG_RESP_OK;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= addr_ok(s_axi_araddr) ? `OOG_RESP_OK : `OOG_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // overhead byte selection
  // ****************************************
  wire [5:0] oh_idx = {row_q, col_q[3:0]};
  wire [3:0] bei_a  = cfg_a_q[`OOG_C_BEIAUTO] ? bei_enc(rx_bip_cnt, rx_biae)
                                              : sm3_a_q[7:4];
  wire       bdi_a  = sm3_a_q[3] | rx_sf;
  wire       iae_a  = sm3_a_q[2] | rx_iae;
  reg  [7:0] byte_d;
  always @* begin
    byte_d = 8'h00;
    if (col_q < `OOG_OH_COLS) begin
      byte_d = oh_mem[{bank_q, oh_idx}];
      if (row_q == 2'd0) begin
        case (col_q[3:0])
          4'd0:    byte_d = fas_a_q[47:40];
          4'd1:    byte_d = fas_a_q[39:32];
          4'd2:    byte_d = fas_a_q[31:24];
          4'd3:    byte_d = fas_a_q[23:16];
          4'd4:    byte_d = fas_a_q[15:8];
          4'd5:    byte_d = fas_a_q[7:0];
          4'd6:    byte_d = mfas_q;
          4'd7:    byte_d = tti_mem[{bank_q, mfas_q[5:0]}];
          4'd9:    byte_d = {bei_a, bdi_a, iae_a, 2'b00};
          default: byte_d = oh_mem[{bank_q, oh_idx}];
        endcase
      end
    end else if (cfg_a_q[`OOG_C_CLIENT] == 5'd0) begin
      byte_d = prbs_step(prbs_q);
    end
  end

  // ****************************************
  // frame timing, commit and interrupts
  // ****************************************
  wire [3:0] ev = {fb & commit_q & cfg_good,
                   fb & commit_q & ~cfg_good,
                   en & last & (mfas_q == 8'hFF),
                   en & (row_q == 2'd0) & (col_q == 14'd0)};
  wire [3:0] int_d = (int_stat_q & ~clr_bits) | ev;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      col_q       <= 14'd0;
      row_q       <= 2'd0;
      mfas_q      <= 8'h00;
      prbs_q      <= 31'h7FFF_FFFF;
      commit_q    <= 1'b0;
      cfg_err_q   <= 1'b0;
      bank_q      <= 1'b0;
      cfg_a_q     <= 32'h0000_0000;
      fas_a_q     <= `OOG_FAS_RST;
      sm3_a_q     <= `OOG_SM3_RST;
      int_stat_q  <= 4'h0;
      irq         <= 1'b0;
      ov_data     <= 8'h00;
      ov_valid    <= 1'b0;
      ov_sof      <= 1'b0;
      ov_oh       <= 1'b0;
      line_rate_q <= 17'd0;
      ts_2g5_q    <= 1'b0;
    end else begin
      int_stat_q <= int_d;
      irq        <= |(int_d & int_en_q);
      ov_valid   <= en;
      ov_sof     <= en & (row_q == 2'd0) & (col_q == 14'd0);
      ov_oh      <= en & (col_q < `OOG_OH_COLS);
      ov_data    <= en ? byte_d : 8'h00;
      line_rate_q <= rate_mbps(cfg_a_q[`OOG_C_OTYPE]);
      ts_2g5_q   <= ts_2g5(cfg_a_q[`OOG_C_MUX1]);
      if (en && col_q >= `OOG_OH_COLS) begin
        prbs_q <= {prbs_q[22:0], prbs_step(prbs_q)};
      end
      if (!en) begin
        col_q <= 14'd0;
        row_q <= 2'd0;
      end else if (col_q == ROW_LEN - 1) begin
        col_q <= 14'd0;
        row_q <= row_q + 2'd1;
      end else begin
        col_q <= col_q + 14'd1;
      end
      if (en && last) begin
        mfas_q <= mfas_q + 8'd1;
      end
      // a new request in the boundary cycle stays pending for the next frame
      if (fb && commit_q) begin
        commit_q  <= req_cm;
        cfg_err_q <= ~cfg_good;
        if (cfg_good) begin
          cfg_a_q <= cfg_s_q;
          fas_a_q <= fas_s_q;
          sm3_a_q <= sm3_s_q;
          bank_q  <= ~bank_q;
        end
      end else if (req_cm) begin
        commit_q <= 1'b1;
      end
    end
  end
endmodule

/* verilog/oog_defs.vh */
`ifndef OOG_DEFS_VH
`define OOG_DEFS_VH

// ****************************************
// register byte addresses
// ****************************************
`define OOG_A_CTRL     8'h00
`define OOG_A_FAS_LO   8'h04
`define OOG_A_FAS_HI   8'h08
`define OOG_A_SM3      8'h0C
`define OOG_A_OHW      8'h10
`define OOG_A_TTIW     8'h14
`define OOG_A_STAT     8'h18
`define OOG_A_RATE     8'h1C
`define OOG_A_INT_STAT 8'h20
`define OOG_A_INT_CLR  8'h24
`define OOG_A_INT_EN   8'h28

// ****************************************
// ctrl fields
// ****************************************
`define OOG_C_EN      0
`define OOG_C_COMMIT  1
`define OOG_C_BEIAUTO 2
`define OOG_C_OTYPE   7:4
`define OOG_C_APP     10:8
`define OOG_C_CLIENT  15:11
`define OOG_C_NLEV    17:16
`define OOG_C_MUX1    22:18
`define OOG_C_MUX2    25:23
`define OOG_C_MUX3    26

// ****************************************
// reset values and frame geometry
// ****************************************
`define OOG_FAS_RST   48'hF6F6_F628_2828
`define OOG_SM3_RST   8'h00
`define OOG_ROW_LEN   3824
`define OOG_OH_COLS   16
`define OOG_ROWS      4
`define OOG_RESP_OK   2'b00
`define OOG_RESP_ERR  2'b10

`endif

/* bench/oog_otn_rx.sv */
`timescale 1ns/1ps
// ****
// far-end receiver
// ****
module oog_otn_rx (
  input  wire        clk,
  input  wire [7:0]  ov_data,
  input  wire        ov_valid,
  input  wire        ov_sof,
  output reg  [47:0] fas,
  output reg  [7:0]  mfas,
  output reg  [7:0]  sm3,
  output reg  [7:0]  tti,
  output reg  [7:0]  oh8,
  output wire [3:0]  bei,
  output wire        biae,
  output reg  [15:0] nfr
);
  reg [47:0] acc;
  reg [15:0] pos;
  integer    p;
  initial nfr = 16'h0000;
  initial pos = 16'h0000;
  assign bei  = (sm3[7:4] > 4'd8) ? 4'd0 : sm3[7:4];
  assign biae = sm3[7:4] == 4'b1011;
  // fas handed out whole at byte 9, so a torn frame shows up
  always @(posedge clk) begin
    if (ov_valid) begin
      p = ov_sof ? 0 : pos;
      pos <= p[15:0] + 16'd1;
      if (p < 6) acc[47 - 8 * p -: 8] <= ov_data;
      if (p == 6) mfas <= ov_data;
      if (p == 7) tti <= ov_data;
      if (p == 8) oh8 <= ov_data;
      if (p == 9) begin
        sm3 <= ov_data;
        fas <= acc;
        nfr <= nfr + 16'd1;
      end
    end
  end
endmodule

/* bench/oog_overhead_gen_checker.sv */
`timescale 1ns/1ps
module oog_overhead_gen_checker #(
  parameter ROW_LEN = 3824
) (
  input wire        clk,
  input wire        resetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire [7:0]  ov_data,
  input wire        ov_valid,
  input wire        ov_sof,
  input wire        ov_oh,
  input wire        irq
);
  localparam int FLEN = 4 * ROW_LEN;
  reg [15:0] cpos_q;
  reg        run_q;
  reg [7:0]  mf_q;
  reg        mfv_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****
  // frame position tracking
  // ****
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpos_q <= 16'h0000;
      run_q  <= 1'b0;
      mf_q   <= 8'h00;
      mfv_q  <= 1'b0;
    end else begin
      cpos_q <= ov_sof ? 16'd1 : (ov_valid ? cpos_q + 16'd1 : cpos_q);
      run_q  <= ov_valid & (run_q | ov_sof);
      mfv_q  <= ov_valid & (mfv_q | (run_q & !ov_sof & cpos_q == 16'd6));
      if (ov_valid && run_q && !ov_sof && cpos_q == 16'd6) mf_q <= ov_data;
    end
  end
  frame_len_a: assert property (ov_valid && run_q |-> ov_sof == (cpos_q == FLEN))
    else $error("frame length wrong");
  rise_sof_a: assert property ($rose(ov_valid) |-> ov_sof)
    else $error("stream did not start on frame");
  oh_cols_a: assert property (ov_valid && run_q && !ov_sof |-> ov_oh == ((cpos_q % ROW_LEN) < 16))
    else $error("overhead column flag wrong");
  mfas_step_a: assert property (ov_valid && mfv_q && !ov_sof && cpos_q == 16'd6 |-> ov_data == mf_q + 8'd1)
    else $error("frame counter step wrong");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  b_after_w_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  r_next_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  busy_ready_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read carried data");
  cover property (ov_sof);
  cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  cover property ($rose(irq));
endmodule
bind oog_overhead_gen oog_overhead_gen_checker #(.ROW_LEN(ROW_LEN)) i_oog_overhead_gen_checker (.*);

/* bench/oog_overhead_gen_test.sv */
`timescale 1ns/1ps
`include "oog_defs.vh"
module oog_overhead_gen_test;
  reg         clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb, rx_bip_cnt;
  reg         rx_biae, rx_sf, rx_iae;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        ov_valid, ov_sof, ov_oh, ts_2g5_q, irq, biae;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0]  ov_data, mfas, sm3, tti, oh8;
  wire [16:0] line_rate_q;
  wire [47:0] fas;
  wire [3:0]  bei;
  wire [15:0] nfr;
  integer     errors, n_tests, cyc, i;
  reg  [31:0] d;
  reg  [1:0]  r;
  reg  [1:0]  b;
  int rate [0:10] = '{2666, 10709, 10709, 11049, 11096, 11270, 11318, 43018, 44571, 44583, 111810};
  int cv [0:6] = '{32'h1000, 32'h0800, 32'h1C_0070, 32'h26_0070, 32'h1E_0070, 32'h9E_0070, 32'h433_0000};
  reg  [6:0]  errv = 7'b110_0101;
  reg  [6:0]  tsv  = 7'b111_0000;
  reg  [6:0]  inv [0:4] = '{7'h28, 7'h60, 7'h04, 7'h02, 7'h01};
  reg  [7:0]  smv [0:4] = '{8'h50, 8'h80, 8'hB0, 8'h08, 8'h04};
  oog_overhead_gen #(.ROW_LEN(20)) i_oog_overhead_gen (.*);
  oog_otn_rx i_oog_otn_rx (.clk(clk), .ov_data(ov_data), .ov_valid(ov_valid), .ov_sof(ov_sof),
    .fas(fas), .mfas(mfas), .sm3(sm3), .tti(tti), .oh8(oh8), .bei(bei), .biae(biae),
    .nfr(nfr));
  // ****
  // shared tasks
  // ****
  task conclude;
    begin
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input string nm, input [47:0] e, input [47:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      // bready stays high so back-to-back calls never re-drive it in one step
      b = s_axi_bresp;
    end
  endtask
  task rd(input [7:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
    end
  endtask
  task wf(input integer n);
    integer t;
    begin
      t = nfr + n;
      while (nfr < t) @(posedge clk);
    end
  endtask
  // ****
  // scenarios
  // ****
  task t_regs;
    begin
      rd(`OOG_A_FAS_LO);
      chk("fas_lo", 32'hF6F6_F628, d);
      rd(`OOG_A_FAS_HI);
      chk("fas_hi", 32'h0000_2828, d);
      rd(8'h3C);
      chk("bad_addr", 34'h0_0000_0000 | {2'b10, 32'h0000_0000}, {r, d});
      wr(8'h3C, 32'h0000_0000);
      chk("bad_wr", 2'b10, b);
    end
  endtask
  task t_rate;
    for (i = 0; i < 11; i = i + 1) begin
      wr(`OOG_A_CTRL, (i << 4) | 32'h0000_0002);
      rd(`OOG_A_STAT);
      chk("line_rate", rate[i], line_rate_q);
    end
  endtask
  task t_cfg;
    for (i = 0; i < 7; i = i + 1) begin
      wr(`OOG_A_CTRL, cv[i] | 32'h0000_0002);
      rd(`OOG_A_STAT);
      chk("cfg_err", errv[i], d[9]);
      chk("ts_2g5", tsv[i], ts_2g5_q);
    end
  endtask
  task t_irq;
    begin
      wr(`OOG_A_INT_EN, 32'h0000_0004);
      rd(`OOG_A_INT_STAT);
      chk("irq_on", 1'b1, irq);
      wr(`OOG_A_INT_EN, 32'h0000_0000);
      rd(`OOG_A_INT_STAT);
      chk("irq_mask", 1'b0, irq);
      wr(`OOG_A_INT_EN, 32'h0000_0004);
      wr(`OOG_A_INT_CLR, 32'h0000_0004);
      rd(`OOG_A_INT_STAT);
      chk("irq_clr", 2'b00, {irq, d[2]});
    end
  endtask
  task t_sm3;
    begin
      wr(`OOG_A_CTRL, 32'h0000_0007);
      wf(2);
      chk("fas_dflt", 48'hF6F6_F628_2828, fas);
      d = mfas;
      wf(1);
      chk("mfas_step", d[7:0] + 8'd1, mfas);
      for (i = 0; i < 5; i = i + 1) begin
        {rx_bip_cnt, rx_biae, rx_sf, rx_iae} <= inv[i];
        wf(3);
        chk("sm3_auto", smv[i], sm3);
        chk("biae", i == 2, biae);
      end
      {rx_bip_cnt, rx_biae, rx_sf, rx_iae} <= 7'h00;
      wr(`OOG_A_SM3, 32'h0000_009C);
      wr(`OOG_A_CTRL, 32'h0000_0003);
      wf(3);
      chk("sm3_sw", 12'h9C0, {sm3, bei});
    end
  endtask
  task t_fas;
    begin
      wr(`OOG_A_FAS_LO, 32'h1122_3344);
      wr(`OOG_A_FAS_HI, 32'h0000_5566);
      wr(`OOG_A_CTRL, 32'h0000_0003);
      for (i = 0; i < 3; i = i + 1) begin
        wf(1);
        chk("fas_whole", 1'b1, fas === 48'hF6F6_F628_2828 || fas === 48'h1122_3344_5566);
      end
      chk("fas_new", 48'h1122_3344_5566, fas);
    end
  endtask
  task t_tti;
    begin
      for (i = 0; i < 64; i = i + 1) begin
        wr(`OOG_A_TTIW, (i << 8) | (i ^ 8'h5A));
      end
      wr(`OOG_A_OHW, 32'h0000_083C);
      wr(`OOG_A_CTRL, 32'h0000_0003);
      wf(2);
      for (i = 0; i < 3; i = i + 1) begin
        wf(1);
        chk("tti_byte", {2'b00, mfas[5:0]} ^ 8'h5A, tti);
        chk("oh_byte", 8'h3C, oh8);
      end
    end
  endtask
  task t_wrap;
    begin
      wr(`OOG_A_INT_CLR, 32'h0000_000F);
      wr(`OOG_A_INT_EN, 32'h0000_0002);
      wf(257);
      chk("mfas_wrap", 1'b1, irq);
    end
  endtask
  // ****
  // clock, reset, run
  // ****
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors = errors + 1;
      conclude;
    end
  end
  initial begin
    {errors, n_tests, cyc} = 0;
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {rx_bip_cnt, rx_biae, rx_sf, rx_iae} = 7'h00;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_rate;
    t_cfg;
    t_irq;
    t_sm3;
    t_fas;
    t_tti;
    t_wrap;
    conclude;
  end
endmodule
